// ### include/rftk_pkg.sv
// Functional notes
// - carrier radiates while data is high, silent while low
// - leaving standby on a rising data edge, carrier starts after about 500 us
// - sync pulse train produced toward the controller while transmitting
// - sync pulses only while data high, none while low
// - no data edge for 300 to 500 ms: standby, rf and pll off
// - sync output held low throughout standby
// - carrier frequency is exactly 32 times the crystal reference
// - enable input tied low; standby governed by data activity only
`default_nettype none
package rftk_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned STARTUP_US     = 500;
  localparam int unsigned STARTUP_CYC    =
    (STARTUP_US * (CLK_HZ / 1_000_000));
  // idle window picked mid-way between the 300 ms and 500 ms bounds
  localparam int unsigned IDLE_MS        = 400;
  localparam int unsigned IDLE_CYC       = IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_HALF_CYC  = 100;
  localparam int unsigned PLL_MULT       = 32;
  localparam int unsigned CNT_W          = 27;
  typedef enum logic [1:0] {
    RFTK_STANDBY,
    RFTK_STARTUP,
    RFTK_ACTIVE
  } rftk_state_e;
endpackage
`default_nettype wire

// ### include/rftk_sync_if.sv
`default_nettype none
interface rftk_sync_if;
  logic run;
  logic pulse;
  modport ctrl (output run, input pulse);
  modport gen  (input run, output pulse);
endinterface
`default_nettype wire

// ### hdl/rftk_sync_gen.sv
`default_nettype none
module rftk_sync_gen
  import rftk_pkg::*;
#(
  parameter int unsigned HALF_CYC = SYNC_HALF_CYC
) (
  input  wire logic  clk_sys,  // system clock
  input  wire logic  resetn,   // async reset, active low
  rftk_sync_if.gen   sync      // run in, pulse out
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        lvl_reg;
  logic        lvl_next;

  always_comb begin
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (!sync.run) begin
      cnt_next = 16'h0000;
      lvl_next = 1'b0;
    end else if (cnt_reg == 16'(HALF_CYC - 1)) begin
      cnt_next = 16'h0000;
      lvl_next = ~lvl_reg;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 16'h0000;
      lvl_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
    end
  end

  assign sync.pulse = lvl_reg;

  property p_sync_quiet;
    @(posedge clk_sys) disable iff (!resetn)
    !sync.run |=> !lvl_reg;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("sync pulse while not running");
endmodule
`default_nettype wire

// ### hdl/rftk_keying_ctrl.sv
`default_nettype none
module rftk_keying_ctrl
  import rftk_pkg::*;
#(
  parameter int unsigned STARTUP_COUNT = STARTUP_CYC,
  parameter int unsigned IDLE_COUNT    = IDLE_CYC
) (
  input  wire logic  clk_sys,           // system clock, 200 MHz
  input  wire logic  resetn,            // async reset, active low
  input  wire logic  tx_data_port_pin,  // keying data from controller
  input  wire logic  tx_enable_pin,     // enable, strapped low
  output logic       rf_carrier_on,     // carrier radiating
  output logic       rf_pll_on,         // pll and rf powered
  output logic       rf_sync_pulse_out, // sync pulse train
  output logic [5:0] pll_mult,          // pll multiplier
  output logic       rf_standby         // standby indication
);
  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  logic s1_reg;
  logic s2_reg;
  logic d_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      d_reg  <= 1'b0;
    end else begin
      s1_reg <= tx_data_port_pin;
      s2_reg <= s1_reg;
      d_reg  <= s2_reg;
    end
  end
  logic data_hi;
  logic data_edge;
  assign data_hi   = s2_reg;
  assign data_edge = s2_reg ^ d_reg;

  // ---------------------------------------------------------------
  // power state and timers
  // ---------------------------------------------------------------
  rftk_state_e      st_reg;
  rftk_state_e      st_next;
  logic [CNT_W-1:0] idle_reg;
  logic [CNT_W-1:0] idle_next;
  logic [CNT_W-1:0] up_reg;
  logic [CNT_W-1:0] up_next;
  logic             unused_en;
  // enable is strapped low, so it plays no part in standby
  assign unused_en = tx_enable_pin;

  always_comb begin
    st_next   = st_reg;
    idle_next = idle_reg;
    up_next   = up_reg;
    case (st_reg)
      RFTK_STANDBY: begin
        idle_next = '0;
        up_next   = '0;
        // wake needs a fresh rising edge; a line parked high stays asleep
        if (data_hi && data_edge) begin
          st_next = RFTK_STARTUP;
        end
      end
      RFTK_STARTUP: begin
        up_next = up_reg + CNT_W'(1);
        if (data_edge) begin
          idle_next = '0;
        end else begin
          idle_next = idle_reg + CNT_W'(1);
        end
        if (up_reg == CNT_W'(STARTUP_COUNT - 1)) begin
          st_next = RFTK_ACTIVE;
        end
        if (idle_reg == CNT_W'(IDLE_COUNT - 1) && !data_edge) begin
          st_next = RFTK_STANDBY;
        end
      end
      RFTK_ACTIVE: begin
        if (data_edge) begin
          idle_next = '0;
        end else if (idle_reg == CNT_W'(IDLE_COUNT - 1)) begin
          st_next   = RFTK_STANDBY;
          idle_next = '0;
        end else begin
          idle_next = idle_reg + CNT_W'(1);
        end
      end
      default: begin
        st_next = RFTK_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg   <= RFTK_STANDBY;
      idle_reg <= '0;
      up_reg   <= '0;
    end else begin
      st_reg   <= st_next;
      idle_reg <= idle_next;
      up_reg   <= up_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic car_reg;
  logic car_next;
  logic pll_reg;
  logic pll_next;
  always_comb begin
    car_next = (st_next == RFTK_ACTIVE) && data_hi;
    pll_next = (st_next != RFTK_STANDBY);
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      car_reg <= 1'b0;
      pll_reg <= 1'b0;
    end else begin
      car_reg <= car_next;
      pll_reg <= pll_next;
    end
  end

  rftk_sync_if sync_bus ();
  // sync runs only while keyed; standby forces it low
  // fed from car_next so sync and carrier fall on one and the same edge
  assign sync_bus.run = car_next;

  rftk_sync_gen u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sync    (sync_bus.gen)
  );

  assign rf_carrier_on     = car_reg;
  assign rf_pll_on         = pll_reg;
  assign rf_standby        = ~pll_reg;
  assign rf_sync_pulse_out = sync_bus.pulse;
  assign pll_mult          = 6'(PLL_MULT);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_carrier_gate;
    @(posedge clk_sys) disable iff (!resetn)
    rf_carrier_on |-> $past(data_hi);
  endproperty
  a_carrier_gate: assert property (p_carrier_gate)
    else $error("carrier on with data low");

  property p_standby_quiet;
    @(posedge clk_sys) disable iff (!resetn)
    rf_standby |-> !rf_sync_pulse_out && !rf_carrier_on;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("activity during standby");

  sequence s_wake;
    rf_standby ##1 !rf_standby;
  endsequence
  property p_startup_delay;
    @(posedge clk_sys) disable iff (!resetn)
    s_wake |-> !rf_carrier_on [*8];
  endproperty
  a_startup_delay: assert property (p_startup_delay)
    else $error("carrier before startup delay");

  property p_idle_timeout;
    @(posedge clk_sys) disable iff (!resetn)
    (idle_reg == CNT_W'(IDLE_COUNT - 1)) && !data_edge
      && st_reg == RFTK_ACTIVE |=> rf_standby;
  endproperty
  a_idle_timeout: assert property (p_idle_timeout)
    else $error("no standby after idle period");

  property p_edge_restart;
    @(posedge clk_sys) disable iff (!resetn)
    data_edge && st_reg != RFTK_STANDBY |=> idle_reg == '0;
  endproperty
  a_edge_restart: assert property (p_edge_restart)
    else $error("idle timer not restarted on edge");

  property p_mult;
    @(posedge clk_sys) disable iff (!resetn)
    pll_mult == 6'h20;
  endproperty
  a_mult: assert property (p_mult)
    else $error("pll multiplier wrong");

  property p_standby_hold;
    @(posedge clk_sys) disable iff (!resetn)
    st_reg == RFTK_STANDBY && !(data_hi && data_edge) |=> rf_standby;
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("left standby without a rising data edge");

  property p_wake;
    @(posedge clk_sys) disable iff (!resetn)
    st_reg == RFTK_STANDBY && data_hi && data_edge
      |=> rf_pll_on && !rf_carrier_on;
  endproperty
  a_wake: assert property (p_wake)
    else $error("rising edge in standby did not start up");

  property p_no_early_carrier;
    @(posedge clk_sys) disable iff (!resetn)
    st_reg != RFTK_ACTIVE |-> !rf_carrier_on;
  endproperty
  a_no_early_carrier: assert property (p_no_early_carrier)
    else $error("carrier outside active state");

  sequence s_keyed;
    st_reg == RFTK_ACTIVE && data_hi
      && (data_edge || idle_reg != CNT_W'(IDLE_COUNT - 1));
  endsequence
  property p_carrier_follow;
    @(posedge clk_sys) disable iff (!resetn)
    s_keyed |=> rf_carrier_on;
  endproperty
  a_carrier_follow: assert property (p_carrier_follow)
    else $error("carrier off while keyed and active");
endmodule
`default_nettype wire

// ### sim/rftk_mcu_model.sv
`default_nettype none
module rftk_mcu_model (
  input  wire logic  clk_sys,             // system clock
  input  wire logic  resetn,              // async reset, active low
  input  wire logic  key_req,             // level asked by the bench
  input  wire logic  sync_input_port_pin, // sync pulses, read only
  output logic       tx_data_port_pin,    // keying data to transmitter
  output logic [7:0] sync_edges           // rising sync edges seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sync_prev_reg;
  // pin is an output from time zero, never left floating
  assign tx_data_port_pin = key_req;
  // sync pin only sampled, its rising edges counted
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_prev_reg <= 1'b0;
      sync_edges    <= 8'h00;
    end else begin
      sync_prev_reg <= sync_input_port_pin;
      if (sync_input_port_pin && !sync_prev_reg) begin
        sync_edges <= sync_edges + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/rf_tx_keying_control_tb_top.sv
`default_nettype none
module rf_tx_keying_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rftk_pkg::*;
  localparam int ST = 20;
  localparam int ID = 400;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       key_req = 1'b0;
  logic       data, car, pll, sync, stby;
  logic [5:0] mult;
  logic [7:0] edges;
  int         err_total = 0;
  int         checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  rftk_keying_ctrl #(.STARTUP_COUNT(ST), .IDLE_COUNT(ID))
    rftk_keying_ctrl_inst (
    .clk_sys(clk_sys), .resetn(resetn), .tx_data_port_pin(data),
    .tx_enable_pin(1'b0), .rf_carrier_on(car), .rf_pll_on(pll),
    .rf_sync_pulse_out(sync), .pll_mult(mult), .rf_standby(stby));
  rftk_mcu_model rftk_mcu_model_inst (
    .clk_sys(clk_sys), .resetn(resetn), .key_req(key_req),
    .sync_input_port_pin(sync), .tx_data_port_pin(data),
    .sync_edges(edges));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic results();
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("standby", {7'h0, stby}, 8'h01);
    chk("carrier", {7'h0, car}, 8'h00);
    chk("sync", {7'h0, sync}, 8'h00);
    chk("pll_mult", {2'h0, mult}, 8'h20);
  endtask
  task automatic t_start();
    int n;
    n = 5;
    key_req = 1'b1;
    cyc(5);
    chk("pll_on", {7'h0, pll}, 8'h01);
    chk("early_car", {7'h0, car}, 8'h00);
    while (car !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("startup", {7'h0, n >= ST && n <= ST + 6}, 8'h01);
    // first sync rise trails the carrier by SYNC_HALF_CYC - 1 cycles
    cyc(3);
    chk("sync_lo", {7'h0, sync}, 8'h00);
    cyc(SYNC_HALF_CYC - 4);
    chk("sync_hi", {7'h0, sync}, 8'h01);
    cyc(SYNC_HALF_CYC - 2);
    chk("sync_hold", {7'h0, sync}, 8'h01);
    cyc(3);
    chk("sync_fall", {7'h0, sync}, 8'h00);
    chk("edges", edges, 8'h01);
  endtask
  task automatic t_low();
    key_req = 1'b0;
    cyc(5);
    chk("car_low", {7'h0, car}, 8'h00);
    chk("sync_low", {7'h0, sync}, 8'h00);
    key_req = 1'b1;
    cyc(5);
    chk("car_back", {7'h0, car}, 8'h01);
    key_req = 1'b0;
  endtask
  task automatic t_idle();
    for (int i = 0; i < 4; i++) begin
      cyc(ID * 3 / 4);
      chk("no_stby", {7'h0, stby}, 8'h00);
      key_req = ~key_req;
    end
    cyc(ID - 20);
    chk("stby_early", {7'h0, stby}, 8'h00);
    cyc(40);
    chk("stby", {7'h0, stby}, 8'h01);
    chk("pll_off", {7'h0, pll}, 8'h00);
    cyc(ID * 2);
    chk("stby_sync", {7'h0, sync}, 8'h00);
    key_req = 1'b1;
    cyc(5);
    chk("restart", {7'h0, car}, 8'h00);
    chk("restart_pll", {7'h0, pll}, 8'h01);
    cyc(ID + 40);
    chk("hi_timeout", {7'h0, stby}, 8'h01);
    chk("hi_car_off", {7'h0, car}, 8'h00);
    chk("hi_sync_off", {7'h0, sync}, 8'h00);
    key_req = 1'b0;
  endtask
  // watchdog sized well beyond the few thousand cycles the run needs
  initial begin
    #(ID * 20 * 5);
    err_total++;
    results();
  end
  initial begin
    cyc(5);
    resetn = 1'b1;
    cyc(2);
    t_reset();
    t_start();
    t_low();
    t_idle();
    results();
  end
endmodule
`default_nettype wire
